// ### hw/window0_bridge.sv
// Purpose: Window 0 target register/decode logic plus error monitor
// Assumes: one clock; serr_n and tgt_in come from outside and are synced
// Notes:   Read data appear the cycle after the read strobe
//
// Operation
// RQ1 - A seen system-error assertion sets the status bit at any time.
// RQ2 - The status bit resets to zero and clears only on a written one.
// RQ3 - The interrupt is raised only when its enable is one; it resets to 0.
// RQ4 - The internal base sits in bits 31:20 and resets to zero.
// RQ5 - The mask in bits 28:20 picks compared bits and resets to 0x03F.
// RQ6 - The burst code maps 1, 4, 8, 16 or 32 words and resets to 3.
// RQ7 - Writing one to cache clear flushes the read cache, then self-clears.
// RQ8 - Prefetch on means prefetching reads, off means one exact burst.
// RQ9 - Prefetch changes never alter the prefetchable bit of the base.
// RQ10 - Software should keep prefetch at default in add-in-card mode.
// RQ11 - With the window off, base writes are ignored and reads give zero.
// RQ12 - Accesses decode only while the window enable is one.
// RQ13 - Byte swap reverses bytes when one; resets per the endian strap.
// RQ14 - Clearing swap in big-endian leaves word byte order as is.
// RQ15 - A hit matches masked upper bits; address is base plus offset.
// RQ16 - Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
module window0_bridge
  import window0_pkg::*;
(
  input  wire logic         core_clk,     // 100 MHz clock
  input  wire logic         rst_n,        // Async reset, active low
  input  wire logic         clk_en,       // Freezes all state when low
  input  wire logic         big_endian,   // Endian strap
  input  wire logic         serr_n,       // System error pin, active low
  input  wire logic [15:0]  reg_addr,     // Register byte address
  input  wire logic [31:0]  reg_wdata,    // Register write data
  input  wire logic         reg_wr,       // Write strobe
  input  wire logic         reg_rd,       // Read strobe
  output logic      [31:0]  reg_rdata,    // Read data, one cycle later
  output logic              irq,          // Level interrupt
  input  wire tgt_req_type  tgt_in,       // Target request, PCI side
  output ibus_req_type      ibus_out,     // Forwarded internal request
  output logic              flush_pulse   // Read cache flush, one cycle
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Burst code to word count
  function automatic logic [5:0] burst_words(input logic [2:0] code);
    logic [5:0] w;
    w = 6'h20;
    if (!code[2])
    begin
      case (code[1:0])
        2'b00:   w = 6'h01;
        2'b01:   w = 6'h04;
        2'b10:   w = 6'h08;
        2'b11:   w = 6'h10;
        default: w = 6'h01;
      endcase
    end
    return w;
  endfunction

  // Reverse byte order of one word
  function automatic logic [31:0] swap32(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic        serr_s1_r;
  logic        serr_s2_r;
  tgt_req_type tgt_s1_r;
  tgt_req_type tgt_s2_r;

  // Two stages; only the second stage is read downstream
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serr_s1_r <= 1'b1;
      serr_s2_r <= 1'b1;
      tgt_s1_r  <= '0;
      tgt_s2_r  <= '0;
    end
    else if (clk_en)
    begin
      serr_s1_r <= serr_n;
      serr_s2_r <= serr_s1_r;
      tgt_s1_r  <= tgt_in;
      tgt_s2_r  <= tgt_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release

  logic strap_done_r;
  logic big_endian_r;

  // Strap is caught by a clocked sample, never by the async reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_r <= 1'b0;
      big_endian_r <= 1'b0;
    end
    else if (clk_en && !strap_done_r)
    begin
      strap_done_r <= 1'b1;
      big_endian_r <= big_endian;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic wr_status;
  logic wr_mask;
  logic wr_origin;
  logic wr_ctrl;
  logic wr_cfgbar;
  logic rd_status;

  assign wr_status = reg_wr && (reg_addr == OFS_ERR_STATUS);
  assign wr_mask   = reg_wr && (reg_addr == OFS_IRQ_MASK);
  assign wr_origin = reg_wr && (reg_addr == OFS_WIN0_ORIGIN);
  assign wr_ctrl   = reg_wr && (reg_addr == OFS_WIN0_CTRL);
  assign wr_cfgbar = reg_wr && (reg_addr == OFS_WIN0_CFGBAR);
  assign rd_status = reg_rd && (reg_addr == OFS_ERR_STATUS);

  ////////////////////////////////////////////////////////////////////////
  // Error status and interrupt enable

  logic serr_seen_r;
  logic serr_irq_en_r;
  logic serr_seen_nxt;

  // Set wins over a same-cycle clear so no assertion is lost
  always_comb
  begin
    serr_seen_nxt = serr_seen_r;
    if (wr_status && reg_wdata[SERR_BIT])
      serr_seen_nxt = 1'b0;                           // RQ2
    if (!serr_s2_r)
      serr_seen_nxt = 1'b1;                           // RQ1
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      serr_seen_r <= 1'b0;                            // RQ2
    else if (clk_en)
      serr_seen_r <= serr_seen_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      serr_irq_en_r <= 1'b0;                          // RQ3
    else if (clk_en && wr_mask)
      serr_irq_en_r <= reg_wdata[SYSTEM_ERROR_IRQ_ENABLE_BIT];
  end

  // Registered so the output comes from a flop
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else if (clk_en)
      irq <= serr_seen_nxt && serr_irq_en_r;          // RQ3
  end

  ////////////////////////////////////////////////////////////////////////
  // Window 0 origin and control

  logic [11:0] origin_r;
  logic [8:0]  mask_r;
  logic [2:0]  burst_r;
  logic        prefetch_r;
  logic        enable_r;
  logic        swap_r;
  logic        swap_init_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      origin_r <= ORIGIN_RST;                         // RQ4
    else if (clk_en && wr_origin)
      origin_r <= reg_wdata[31:ORIGIN_LSB];           // RQ4
  end

  // Reserved control bits are simply not stored
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_r     <= MASK_RST;                         // RQ5
      burst_r    <= BURST_RST;                        // RQ6
      prefetch_r <= PREFETCH_RST;                     // RQ8
      enable_r   <= ENABLE_RST;                       // RQ12
    end
    else if (clk_en && wr_ctrl)
    begin
      mask_r     <= reg_wdata[MASK_MSB:MASK_LSB];     // RQ5
      burst_r    <= reg_wdata[BURST_MSB:BURST_LSB];   // RQ6
      prefetch_r <= reg_wdata[PREFETCH_BIT];          // RQ8
      enable_r   <= reg_wdata[ENABLE_BIT];            // RQ12
    end
  end

  // Swap default follows the strap until software writes it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swap_r      <= 1'b0;
      swap_init_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
      begin
        swap_r      <= reg_wdata[SWAP_BIT];           // RQ13
        swap_init_r <= 1'b1;
      end
      else if (strap_done_r && !swap_init_r)
      begin
        swap_r      <= big_endian_r;                  // RQ13
        swap_init_r <= 1'b1;
      end
    end
  end

  // Flush is a one-cycle pulse; the bit never holds a one
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flush_pulse <= 1'b0;
    else if (clk_en)
      flush_pulse <= wr_ctrl && reg_wdata[FLUSH_BIT]; // RQ7
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration-space base for window 0

  logic [11:0] cfgbar_r;

  // Writes are dropped while the window is off
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfgbar_r <= 12'h000;
    else if (clk_en && wr_cfgbar && enable_r)
      cfgbar_r <= reg_wdata[31:ORIGIN_LSB];           // RQ11
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read-back

  logic [31:0] rdata_nxt;

  // Unmapped and reserved bits read as zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      OFS_ERR_STATUS:  rdata_nxt[SERR_BIT] = serr_seen_r;
      OFS_IRQ_MASK:    rdata_nxt[SYSTEM_ERROR_IRQ_ENABLE_BIT] = serr_irq_en_r;
      OFS_WIN0_ORIGIN: rdata_nxt[31:ORIGIN_LSB] = origin_r;
      OFS_WIN0_CTRL:
      begin
        rdata_nxt[MASK_MSB:MASK_LSB]   = mask_r;      // RQ16
        rdata_nxt[BURST_MSB:BURST_LSB] = burst_r;
        rdata_nxt[PREFETCH_BIT]        = prefetch_r;
        rdata_nxt[ENABLE_BIT]          = enable_r;
        rdata_nxt[SWAP_BIT]            = swap_r;
      end
      OFS_WIN0_CFGBAR:
      begin
        // Attribute is fixed, prefetch setting never shows here
        if (enable_r)                                  // RQ11
          rdata_nxt = {cfgbar_r, 16'h0000, PREFETCH_BAR_ATTR}; // RQ9
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en && reg_rd)
      reg_rdata <= rdata_nxt;
    else if (clk_en)
      reg_rdata <= 32'h0000_0000;
  end

  // Read of the status register is not destructive here; W1C only
  logic unused_rd;
  assign unused_rd = rd_status;

  ////////////////////////////////////////////////////////////////////////
  // Target decode and forwarding

  logic [31:0] cmp_mask;
  logic        hit;
  logic [31:0] ibus_addr;
  logic [31:0] fwd_data;

  assign cmp_mask = {3'b000, mask_r, 20'h0_0000};
  // Masked upper bits compare against the configured base
  assign hit = tgt_s2_r.valid && enable_r &&                 // RQ12
               (((tgt_s2_r.addr ^ {cfgbar_r, 20'h0_0000})
                 & cmp_mask) == 32'h0000_0000);              // RQ15
  assign ibus_addr = ({origin_r, 20'h0_0000} & cmp_mask)
                   | (tgt_s2_r.addr & ~cmp_mask);            // RQ15
  // Swap applies only when the bit is one; zero passes as is
  assign fwd_data = swap_r ? swap32(tgt_s2_r.data)           // RQ13
                           : tgt_s2_r.data;                  // RQ14

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ibus_out <= '0;
    else if (clk_en)
    begin
      ibus_out.valid    <= hit;
      ibus_out.write    <= tgt_s2_r.write;
      ibus_out.prefetch <= prefetch_r;                       // RQ8
      ibus_out.words    <= burst_words(burst_r);             // RQ6
      ibus_out.addr     <= ibus_addr;
      ibus_out.data     <= fwd_data;
    end
  end

endmodule

// ### hw/window0_pkg.sv
// Purpose: Constants and carriers for target window 0 and error monitor
// Assumes: 32-bit register port, word addressed by byte offset
// Notes:   Offsets are byte addresses of the controller register space
package window0_pkg;

  localparam logic [15:0] OFS_ERR_STATUS  = 16'hd174;
  localparam logic [15:0] OFS_IRQ_MASK    = 16'hd178;
  localparam logic [15:0] OFS_WIN0_ORIGIN = 16'hd180;
  localparam logic [15:0] OFS_WIN0_CTRL   = 16'hd184;
  // Window 0 configuration-space base, owned by this block
  localparam logic [15:0] OFS_WIN0_CFGBAR = 16'hd1f0;

  localparam int SERR_BIT      = 0;
  localparam int SYSTEM_ERROR_IRQ_ENABLE_BIT    = 0;
  localparam int ORIGIN_LSB    = 20;
  localparam int MASK_LSB      = 20;
  localparam int MASK_MSB      = 28;
  localparam int BURST_LSB     = 8;
  localparam int BURST_MSB     = 10;
  localparam int FLUSH_BIT     = 4;
  localparam int PREFETCH_BIT  = 2;
  localparam int ENABLE_BIT    = 1;
  localparam int SWAP_BIT      = 0;

  localparam logic [11:0] ORIGIN_RST   = 12'h000;
  localparam logic [8:0]  MASK_RST     = 9'h03f;
  localparam logic [2:0]  BURST_RST    = 3'h3;
  localparam logic        PREFETCH_RST = 1'b1;
  localparam logic        ENABLE_RST   = 1'b0;
  localparam logic [3:0]  PREFETCH_BAR_ATTR = 4'h8;

  // Target request from the PCI side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } tgt_req_type;

  // Request forwarded to the internal bus
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        prefetch;
    logic [5:0]  words;
    logic [31:0] addr;
    logic [31:0] data;
  } ibus_req_type;

endpackage

// ### tb/window0_bridge_asserts.sv
// Purpose: Port-level checks of the window 0 bridge
// Assumes: Shadows rebuild control fields from bus writes
// Notes:   Requests are sent only while control is steady
`timescale 1ns/100ps
module window0_bridge_asserts
  import window0_pkg::*;
(
  input wire logic         core_clk,     // Clock
  input wire logic         rst_n,        // Reset, active low
  input wire logic         clk_en,       // Run enable
  input wire logic         serr_n,       // System error, active low
  input wire logic [15:0]  reg_addr,     // Register address
  input wire logic [31:0]  reg_wdata,    // Write data
  input wire logic         reg_wr,       // Write strobe
  input wire logic         reg_rd,       // Read strobe
  input wire logic [31:0]  reg_rdata,    // Read data
  input wire logic         irq,          // Interrupt
  input wire tgt_req_type  tgt_in,       // Target request
  input wire ibus_req_type ibus_out,     // Forwarded request
  input wire logic         flush_pulse   // Cache flush
);
  logic       irq_en_r;
  logic       win_en_r;
  logic       pref_r;
  logic [2:0] burst_r;
  logic       ctl_wr;
  logic       clr_wr;
  ////////////////////////////////////////////////////////////////////////////
  // Strobes as the bridge takes them
  assign ctl_wr = reg_wr && clk_en && reg_addr == OFS_WIN0_CTRL;
  assign clr_wr = reg_wr && clk_en && reg_addr == OFS_ERR_STATUS;
  function automatic logic [5:0] words_for(input logic [2:0] c);
    return c[2] ? 6'h20 : (c == 3'h0) ? 6'h01 : 6'h02 << c;
  endfunction
  // Shadow fields; only what the bus wrote, no peeking inside
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      irq_en_r <= 1'b0;
      win_en_r <= 1'b0;
      pref_r   <= 1'b1;
      burst_r  <= 3'h3;
    end
    else
    begin
      if (reg_wr && clk_en && reg_addr == OFS_IRQ_MASK)
        irq_en_r <= reg_wdata[SYSTEM_ERROR_IRQ_ENABLE_BIT];
      if (ctl_wr)
      begin
        win_en_r <= reg_wdata[ENABLE_BIT];
        pref_r   <= reg_wdata[PREFETCH_BIT];
        burst_r  <= reg_wdata[BURST_MSB:BURST_LSB];
      end
    end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence serr_seen_s;
    !serr_n && irq_en_r && !clr_wr;
  endsequence
  sequence quiet_s;
    (irq_en_r && !clr_wr) [*4];
  endsequence
  a_serr_sets_irq: assert property (
    serr_seen_s ##1 quiet_s |-> irq)
    else $error("irq missing after system error");
  a_irq_masked: assert property (
    !irq_en_r && !$past(irq_en_r) |-> !irq)
    else $error("irq raised while disabled");
  a_flush_follows: assert property (
    ctl_wr && reg_wdata[FLUSH_BIT] |=> flush_pulse)
    else $error("no flush after cache clear write");
  a_flush_cause: assert property (
    flush_pulse |-> $past(ctl_wr && reg_wdata[FLUSH_BIT]))
    else $error("flush without a cache clear write");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_off_no_hit: assert property ((tgt_in.valid && !win_en_r) ##1 (!win_en_r) [*3]
    |-> !ibus_out.valid) else $error("disabled window forwarded");
  a_valid_cause: assert property (ibus_out.valid |-> $past(tgt_in.valid, 3))
    else $error("forward without request");
  a_read_shape: assert property (ibus_out.valid && !ibus_out.write |->
    ibus_out.words == words_for(burst_r) && ibus_out.prefetch == pref_r)
    else $error("read burst shape wrong");
endmodule
bind window0_bridge window0_bridge_asserts u_chk (.core_clk, .rst_n, .clk_en,
  .serr_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
  .tgt_in, .ibus_out, .flush_pulse);

// ### tb/pci_master_model.sv
// Purpose: PCI master stand-in for target requests and system errors
// Assumes: Tasks are entered just after a rising edge or at start
// Notes:   Lines not qualified by valid carry inverted values
`timescale 1ns/100ps
module pci_master_model
  import window0_pkg::*;
(
  input wire logic core_clk,  // Clock
  output tgt_req_type tgt_out,   // Request to the bridge
  output logic        serr_n     // System error, active low
);
  // Idle at time zero
  initial
  begin
    tgt_out = '0;
    serr_n  = 1'b1;
  end
  // One request per call; stale lines are scrambled, never held
  task automatic issue(input logic w, input logic [31:0] a, d);
    @(posedge core_clk);
    tgt_out <= '{valid: 1'b1, write: w, addr: a, data: d};
    @(posedge core_clk);
    tgt_out <= '{valid: 1'b0, write: !w, addr: ~a, data: ~d};
  endtask
  // Single-cycle error, the shortest the synchroniser must catch
  task automatic pulse_serr();
    @(posedge core_clk);
    serr_n <= 1'b0;
    @(posedge core_clk);
    serr_n <= 1'b1;
  endtask
endmodule

// ### tb/tb_pci_target_window0_and_serr.sv
// Purpose: Self-checking bench for the window 0 bridge
// Assumes: clk_en tied high; strap changed only across resets
// Notes:   Expected values are built here from field layouts
`timescale 1ns/100ps
module tb_pci_target_window0_and_serr
  import window0_pkg::*;
;
  logic         core_clk;
  logic         rst_n;
  logic         big_endian;
  logic [15:0]  reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_rdata;
  logic         irq;
  logic         serr_n;
  logic         flush_pulse;
  tgt_req_type  tgt_in;
  ibus_req_type ibus_out;
  int           n_mismatch;
  int           compares;
  int           cyc;
  ////////////////////////////////////////////////////////////////////////////
  window0_bridge dut (.core_clk, .rst_n, .clk_en(1'b1), .big_endian,
    .serr_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .tgt_in, .ibus_out, .flush_pulse);
  pci_master_model mdl (.core_clk, .tgt_out(tgt_in), .serr_n);
  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, generous against some 220 cycles of tests
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [5:0] words_for(input logic [2:0] c);
    return c[2] ? 6'h20 : (c == 3'h0) ? 6'h01 : 6'h02 << c;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask
  task automatic do_reset(input logic be);
    @(posedge core_clk);
    rst_n      <= 1'b0;
    big_endian <= be;
    repeat (2) @(posedge core_clk);
    rst_n      <= 1'b1;
  endtask
  // Bounded watch for the forwarded request
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic hit, output ibus_req_type got);
    hit = 1'b0;
    got = '0;
    mdl.issue(w, a, d);
    repeat (5)
    begin
      @(posedge core_clk);
      #1;
      if (ibus_out.valid === 1'b1 && !hit)
      begin
        hit = 1'b1;
        got = ibus_out;
      end
    end
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] c, input logic e, s);
    return {3'h0, 9'h1FF, 9'h000, c, 5'h00, c[0], e, s};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset(input logic be);
    rd(OFS_ERR_STATUS, 32'h0000_0000);
    rd(OFS_IRQ_MASK, 32'h0000_0000);
    rd(OFS_WIN0_ORIGIN, 32'h0000_0000);
    rd(OFS_WIN0_CTRL, {31'h01F8_0182, be});
    rd(OFS_WIN0_CFGBAR, 32'h0000_0000);
    rd(16'h0000, 32'h0000_0000);
    $display("reset values done");
  endtask
  task automatic t_regs();
    wr(OFS_WIN0_CFGBAR, 32'hFFFF_FFFF);
    wr(OFS_WIN0_ORIGIN, 32'hFFFF_FFFF);
    rd(OFS_WIN0_ORIGIN, 32'hFFF0_0000);
    wr(OFS_WIN0_CTRL, 32'hFFFF_FFEE);
    rd(OFS_WIN0_CTRL, 32'h1FF0_0706);
    rd(OFS_WIN0_CFGBAR, 32'h0000_0008);
    wr(OFS_WIN0_CTRL, 32'h1FF0_0702);
    wr(OFS_WIN0_CFGBAR, 32'h1230_0000);
    rd(OFS_WIN0_CFGBAR, 32'h1230_0008);
    wr(OFS_WIN0_CTRL, 32'h1FF0_0712);
    #1 chk("flush pulse", 32'h1, 32'(flush_pulse));
    rd(OFS_WIN0_CTRL, 32'h1FF0_0702);
    wr(OFS_IRQ_MASK, 32'hFFFF_FFFF);
    rd(OFS_IRQ_MASK, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    $display("register access done");
  endtask
  task automatic t_serr();
    mdl.pulse_serr();
    repeat (6) @(posedge core_clk);
    #1 chk("irq masked", 32'h0, 32'(irq));
    rd(OFS_ERR_STATUS, 32'h0000_0001);
    wr(OFS_ERR_STATUS, 32'h0000_0000);
    rd(OFS_ERR_STATUS, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    // The level output is a flop, one edge behind the enable
    @(posedge core_clk);
    #1 chk("irq pending", 32'h1, 32'(irq));
    wr(OFS_ERR_STATUS, 32'h0000_0001);
    rd(OFS_ERR_STATUS, 32'h0000_0000);
    chk("irq cleared", 32'h0, 32'(irq));
    mdl.pulse_serr();
    repeat (6) @(posedge core_clk);
    #1 chk("irq raised", 32'h1, 32'(irq));
    wr(OFS_ERR_STATUS, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    $display("system error done");
  endtask
  // Burst codes 0 to 4 and 7 with prefetch and swap varied alongside
  task automatic t_target();
    logic         hit;
    ibus_req_type got;
    logic [2:0]   c;
    wr(OFS_WIN0_ORIGIN, 32'hABC0_0000);
    for (int i = 0; i < 6; i++)
    begin
      c = (i == 5) ? 3'h7 : 3'(i);
      wr(OFS_WIN0_CTRL, ctl(c, 1'b1, c[1]));
      xfer(1'b0, 32'h1234_5678, 32'h0, hit, got);
      chk("read hit", 32'h1, 32'(hit));
      chk("ibus addr", 32'h0BC4_5678, got.addr);
      chk("words", 32'(words_for(c)), 32'(got.words));
      chk("prefetch", 32'(c[0]), 32'(got.prefetch));
      xfer(1'b1, 32'h1239_0000, 32'h1122_3344, hit, got);
      chk("write", 32'h1, 32'(got.write));
      chk("wdata", c[1] ? 32'h4433_2211 : 32'h1122_3344, got.data);
    end
    xfer(1'b0, 32'h0234_5678, 32'h0, hit, got);
    chk("miss", 32'h0, 32'(hit));
    wr(OFS_WIN0_CTRL, ctl(3'h3, 1'b0, 1'b0));
    xfer(1'b0, 32'h1234_5678, 32'h0, hit, got);
    chk("disabled", 32'h0, 32'(hit));
    $display("target forwarding done");
  endtask
  task automatic t_endian();
    logic         hit;
    ibus_req_type got;
    do_reset(1'b1);
    t_reset(1'b1);
    wr(OFS_WIN0_CTRL, ctl(3'h0, 1'b1, 1'b0));
    wr(OFS_WIN0_CFGBAR, 32'h1230_0000);
    xfer(1'b1, 32'h1230_0010, 32'h1122_3344, hit, got);
    chk("be wdata", 32'h1122_3344, got.data);
    $display("big endian done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n      = 1'b0;
    big_endian = 1'b0;
    reg_addr   = 16'h0000;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    do_reset(1'b0);
    t_reset(1'b0);
    t_regs();
    t_serr();
    t_target();
    t_endian();
    tally_and_finish();
  end
endmodule
